// ### hbds_top.v
/*
 H-bridge drive sequencer top: clock select, divide-by-two, watchdog,
 protection and AXI4-Lite registers.
 Assumes mode, clock pin, undervoltage and overtemperature are async pins.
*/
// Notes on behaviour
// - Mode high uses internal oscillator; mode low uses clock pin.
// - External clock divided by two in a toggle flop, 50% duty.
// - External mode phase changes only on clock pin rising edges.
// - Drive phase always from a divide-by-two stage, fixed 50% duty.
// - With mode low, watchdog disables bridge when clock pin is static over 55 us.
// - After watchdog stop, next clock pin rising edge resumes switching.
// - Mode low in oscillator mode stops switching within 55 us.
// - Disabled device resumes on mode high or clock toggling again.
// - Undervoltage indication keeps the bridge disabled.
// - Overtemperature indication disables; its release (hysteresis) re-enables.
// - Break-before-make: both legs off before the opposite turns on.
`timescale 1ns/1ps
`include "hbds_defines.vh"
module hbds_top
#(
    parameter WDOG_CYC = `HBDS_WDOG_CYC,
    parameter OSC_DIV = `HBDS_OSC_DIV_DEF
)
(
    input wire clk,
    input wire rst,
    input wire mode_pin,
    input wire clock_or_rate_pin,
    input wire uvlo_pin,
    input wire overtemp_pin,
    output reg drive_out_a,
    output reg drive_out_b,
    output reg irq,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire mode_s;
    wire ck_s;
    wire uv_s;
    wire ot_s;
    hbds_sync u_sync_mode (.clk(clk), .rst(rst), .async_in(mode_pin), .sync_out(mode_s));
    hbds_sync u_sync_ck (.clk(clk), .rst(rst), .async_in(clock_or_rate_pin), .sync_out(ck_s));
    hbds_sync u_sync_uv (.clk(clk), .rst(rst), .async_in(uvlo_pin), .sync_out(uv_s));
    hbds_sync u_sync_ot (.clk(clk), .rst(rst), .async_in(overtemp_pin), .sync_out(ot_s));

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg ctrl_en;
    reg [`HBDS_EV_W-1:0] irq_stat;
    reg [`HBDS_EV_W-1:0] irq_mask;
    reg [15:0] osc_div;

    // ----------------------------------------
    // Edge detect and internal oscillator enable
    // ----------------------------------------
    reg ck_d;
    reg [15:0] osc_cnt;
    reg osc_tick;
    wire ck_rise = ck_s & ~ck_d;
    wire ck_edge = ck_s ^ ck_d;
    always @(posedge clk)
    begin
        if (rst)
        begin
            ck_d <= 1'b0;
            osc_cnt <= 16'h0000;
            osc_tick <= 1'b0;
        end
        else
        begin
            ck_d <= ck_s;
            osc_tick <= 1'b0;
            if (osc_cnt >= osc_div - 16'h0001)
            begin
                osc_cnt <= 16'h0000;
                osc_tick <= 1'b1;
            end
            else
            begin
                osc_cnt <= osc_cnt + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Watchdog and disable
    // ----------------------------------------
    reg [31:0] wdog_cnt;
    reg wdog_trip;
    always @(posedge clk)
    begin
        if (rst)
        begin
            wdog_cnt <= 32'h00000000;
            wdog_trip <= 1'b0;
        end
        else if (mode_s || ck_edge)
        begin
            wdog_cnt <= 32'h00000000;
            if (mode_s || ck_rise)
            begin
                wdog_trip <= 1'b0;
            end
        end
        else if (wdog_cnt >= WDOG_CYC - 1)
        begin
            wdog_trip <= 1'b1;
        end
        else
        begin
            wdog_cnt <= wdog_cnt + 32'h00000001;
        end
    end

    // Mode low with no clock edges trips the same watchdog, stopping within the bound
    wire run = ctrl_en & ~wdog_trip & ~uv_s & ~ot_s;

    // ----------------------------------------
    // Divide-by-two phase
    // ----------------------------------------
    reg phase;
    wire step = mode_s ? osc_tick : ck_rise;
    always @(posedge clk)
    begin
        if (rst)
        begin
            phase <= 1'b0;
        end
        else if (run && step)
        begin
            phase <= ~phase;
        end
    end

    wire leg_a;
    wire leg_b;
    hbds_deadtime u_dead (.clk(clk), .rst(rst), .phase(phase), .enable(run), .out_a(leg_a), .out_b(leg_b));

    // ----------------------------------------
    // Events and outputs
    // ----------------------------------------
    reg run_d;
    reg wdog_d;
    reg uv_d;
    reg ot_d;
    wire [`HBDS_EV_W-1:0] ev;
    assign ev = {run_d & ~run, ot_s & ~ot_d, uv_s & ~uv_d, wdog_trip & ~wdog_d};
    wire wr_fire;
    wire [`HBDS_EV_W-1:0] clr = (wr_fire && s_axi_awaddr == `HBDS_ADDR_IRQ && s_axi_wstrb[0]) ?
        s_axi_wdata[`HBDS_EV_W-1:0] : {`HBDS_EV_W{1'b0}};
    always @(posedge clk)
    begin
        if (rst)
        begin
            run_d <= 1'b0;
            wdog_d <= 1'b0;
            uv_d <= 1'b0;
            ot_d <= 1'b0;
            irq_stat <= {`HBDS_EV_W{1'b0}};
            irq <= 1'b0;
            drive_out_a <= 1'b0;
            drive_out_b <= 1'b0;
        end
        else
        begin
            run_d <= run;
            wdog_d <= wdog_trip;
            uv_d <= uv_s;
            ot_d <= ot_s;
            irq_stat <= (irq_stat & ~clr) | ev;
            irq <= |(irq_stat & irq_mask);
            drive_out_a <= leg_a;
            drive_out_b <= leg_b;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HBDS_RESP_OKAY;
            ctrl_en <= 1'b1;
            irq_mask <= {`HBDS_EV_W{1'b0}};
            osc_div <= OSC_DIV[15:0];
        end
        else
        begin
            s_axi_awready <= wr_fire;
            s_axi_wready <= wr_fire;
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `HBDS_RESP_OKAY;
                case (s_axi_awaddr)
                    `HBDS_ADDR_CTRL:
                    begin
                        if (s_axi_wstrb[0])
                        begin
                            ctrl_en <= s_axi_wdata[`HBDS_CTRL_EN];
                        end
                    end
                    `HBDS_ADDR_MASK:
                    begin
                        if (s_axi_wstrb[0])
                        begin
                            irq_mask <= s_axi_wdata[`HBDS_EV_W-1:0];
                        end
                    end
                    `HBDS_ADDR_STAT:
                    begin
                        if (s_axi_wstrb[0])
                        begin
                            osc_div[7:0] <= s_axi_wdata[7:0];
                        end
                        if (s_axi_wstrb[1])
                        begin
                            osc_div[15:8] <= s_axi_wdata[15:8];
                        end
                    end
                    `HBDS_ADDR_IRQ:
                    begin
                        s_axi_bresp <= `HBDS_RESP_OKAY;
                    end
                    default:
                    begin
                        s_axi_bresp <= `HBDS_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    wire rd_fire = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HBDS_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= rd_fire;
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `HBDS_RESP_OKAY;
                case (s_axi_araddr)
                    `HBDS_ADDR_CTRL:
                    begin
                        s_axi_rdata <= {31'h00000000, ctrl_en};
                    end
                    `HBDS_ADDR_STAT:
                    begin
                        s_axi_rdata <= {osc_div, 11'h000, ot_s, uv_s, mode_s, wdog_trip, run};
                    end
                    `HBDS_ADDR_IRQ:
                    begin
                        s_axi_rdata <= {28'h0000000, irq_stat};
                    end
                    `HBDS_ADDR_MASK:
                    begin
                        s_axi_rdata <= {28'h0000000, irq_mask};
                    end
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `HBDS_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule // hbds_top

// ### hbds_defines.vh
/*
 Timing and register constants for the H-bridge drive sequencer.
 Assumes a 125 MHz system clock and an AXI4-Lite register bus.
*/
`ifndef HBDS_DEFINES_VH
`define HBDS_DEFINES_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define HBDS_CLK_MHZ 125
`define HBDS_WDOG_US 55
// Sync, edge detect and output stages taken off the limit
`define HBDS_WDOG_LAT 8
`define HBDS_WDOG_CYC (`HBDS_WDOG_US * `HBDS_CLK_MHZ - `HBDS_WDOG_LAT)
`define HBDS_DEAD_NS 20
`define HBDS_DEAD_CYC ((`HBDS_DEAD_NS * `HBDS_CLK_MHZ + 999) / 1000)
`define HBDS_OSC_DIV_DEF 625
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define HBDS_ADDR_CTRL 4'h0
`define HBDS_ADDR_STAT 4'h4
`define HBDS_ADDR_IRQ 4'h8
`define HBDS_ADDR_MASK 4'hc
// ----------------------------------------
// Field positions
// ----------------------------------------
`define HBDS_CTRL_EN 0
`define HBDS_ST_RUN 0
`define HBDS_ST_WDOG 1
`define HBDS_ST_MODE 2
`define HBDS_ST_UV 3
`define HBDS_ST_OT 4
`define HBDS_EV_WDOG 0
`define HBDS_EV_UV 1
`define HBDS_EV_OT 2
`define HBDS_EV_STOP 3
`define HBDS_EV_W 4
`define HBDS_RESP_OKAY 2'h0
`define HBDS_RESP_SLVERR 2'h2
`endif

// ### hbds_sync.v
/*
 Two-flop synchroniser for one asynchronous level.
 Assumes the input is a pin outside the clk domain.
*/
`timescale 1ns/1ps
module hbds_sync
(
    input wire clk,
    input wire rst,
    input wire async_in,
    output reg sync_out
);
    reg stage1;
    always @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // hbds_sync

// ### hbds_deadtime.v
/*
 Break-before-make output stage for the two drive legs.
 Assumes phase and enable come from logic on clk.
*/
`timescale 1ns/1ps
`include "hbds_defines.vh"
module hbds_deadtime
#(
    parameter DEAD_CYC = `HBDS_DEAD_CYC
)
(
    input wire clk,
    input wire rst,
    input wire phase,
    input wire enable,
    output reg out_a,
    output reg out_b
);
    reg [7:0] dead_cnt;
    reg last_phase;
    reg last_en;
    always @(posedge clk)
    begin
        if (rst)
        begin
            out_a <= 1'b0;
            out_b <= 1'b0;
            dead_cnt <= 8'h00;
            last_phase <= 1'b0;
            last_en <= 1'b0;
        end
        else
        begin
            last_phase <= phase;
            last_en <= enable;
            if (!enable)
            begin
                out_a <= 1'b0;
                out_b <= 1'b0;
                dead_cnt <= 8'h00;
            end
            else if (phase != last_phase || !last_en)
            begin
                out_a <= 1'b0;
                out_b <= 1'b0;
                dead_cnt <= DEAD_CYC[7:0];
            end
            else if (dead_cnt > 8'h01)
            begin
                dead_cnt <= dead_cnt - 8'h01;
            end
            else
            begin
                dead_cnt <= 8'h00;
                out_a <= phase;
                out_b <= ~phase;
            end
        end
    end
endmodule // hbds_deadtime

// ### hbds_ext_clk.sv
/* External clock source for the shared clock pin.
   Assumes clk is the bench clock and half is given in clk cycles. */
`timescale 1ns/1ps
module hbds_ext_clk
(
    input wire clk,
    input wire run,
    input wire [7:0] half,
    output logic pin
);
// ----------
// Toggling
// ----------
logic [7:0] cnt;
initial
begin
    pin = 1'b0;
    cnt = 8'h0;
end
// Stopped source holds its last level
always @(posedge clk)
begin
    if (run)
    begin
        cnt <= (cnt >= half - 8'h1) ? 8'h0 : cnt + 8'h1;
        if (cnt >= half - 8'h1)
            pin <= ~pin;
    end
end
endmodule // hbds_ext_clk

// ### hbds_top_assertions.sv
/* Checker on the drive pins of hbds_top.
   Assumes it is bound into hbds_top. */
`timescale 1ns/1ps
module hbds_chk
#(
    parameter WDOG_CYC = 50,
    parameter OSC_DIV = 16
)
(
    input wire clk,
    input wire rst,
    input wire mode_pin,
    input wire clock_or_rate_pin,
    input wire uvlo_pin,
    input wire overtemp_pin,
    input wire drive_out_a,
    input wire drive_out_b,
    input wire irq
);
// ----------
// Helpers
// ----------
reg prev_pin;
integer stall;
integer age;
integer idle;
always @(posedge clk)
begin
    prev_pin <= clock_or_rate_pin;
    stall <= (rst || mode_pin || clock_or_rate_pin != prev_pin) ? 0 : stall + 1;
    age <= (rst || (clock_or_rate_pin && !prev_pin)) ? 0 : (age < 99 ? age + 1 : age);
    idle <= (rst || !mode_pin || uvlo_pin || overtemp_pin || drive_out_a) ? 0 : idle + 1;
end
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
// ----------
// Properties
// ----------
a_no_overlap: assert property (!(drive_out_a && drive_out_b))
    else $error("both legs on");
a_bbm_gap: assert property ($fell(drive_out_b) |=> !drive_out_a [*2])
    else $error("no dead time");
a_uv_off: assert property (uvlo_pin [*8] |-> !drive_out_a && !drive_out_b)
    else $error("drive in undervoltage");
a_ot_off: assert property (overtemp_pin [*8] |-> !drive_out_a && !drive_out_b)
    else $error("drive in overtemperature");
a_wdog_stop: assert property (stall > WDOG_CYC + 12 |-> !drive_out_a && !drive_out_b)
    else $error("stalled clock still drives");
a_ext_rise: assert property (($rose(drive_out_a) || $rose(drive_out_b)) && !mode_pin
    && $past(mode_pin, 8) == 1'b0 |-> age <= 12) else $error("switch not after rising edge");
a_wdog_resume: assert property (clock_or_rate_pin && !prev_pin && stall > WDOG_CYC + 12
    && !uvlo_pin && !overtemp_pin |-> ##[1:14] (drive_out_a || drive_out_b)) else $error("no resume");
a_osc_runs: assert property (idle < 3 * OSC_DIV + 10)
    else $error("oscillator mode idle");
cover property ($rose(drive_out_a) && !mode_pin);
cover property (stall == WDOG_CYC + 13);
cover property (irq);
endmodule // hbds_chk
bind hbds_top hbds_chk #(.WDOG_CYC(WDOG_CYC), .OSC_DIV(OSC_DIV)) chk_i
(
    .clk, .rst, .mode_pin, .clock_or_rate_pin, .uvlo_pin, .overtemp_pin, .drive_out_a, .drive_out_b, .irq
);

// ### hbds_top_tb.sv
/* Self-checking bench for hbds_top.
   Assumes hbds_ext_clk and the bound checker are compiled first. */
`timescale 1ns/1ps
module hbds_top_tb;
localparam WD = 50;
localparam OD = 16;
logic clk, rst, mode_pin, uvlo_pin, overtemp_pin, run;
logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
logic [31:0] s_axi_wdata, d;
logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire clock_or_rate_pin, drive_out_a, drive_out_b, irq;
logic [1:0] r;
logic [37:0] rows [0:3];
integer err_total, n_checks, n, i, k;
hbds_top #(.WDOG_CYC(WD), .OSC_DIV(OD)) uut
(
    .clk, .rst, .mode_pin, .clock_or_rate_pin, .uvlo_pin, .overtemp_pin, .drive_out_a, .drive_out_b, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
hbds_ext_clk src (.clk, .run, .half(8'h0c), .pin(clock_or_rate_pin));
initial
begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
// ----------
// Tasks
// ----------
task chk_w(input string nm, input [31:0] e, input [31:0] g);
begin
    n_checks++;
    if (g !== e)
    begin
        err_total++;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
end
endtask
task axw(input [3:0] ad, input [31:0] dt);
    integer t;
    reg dn;
begin
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    dn = 0;
    t = 0;
    while (!dn && t < 50)
    begin
        @(posedge clk);
        t++;
        if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
            s_axi_bready <= 1'b0;
            dn = 1;
            chk_w("bresp", 0, s_axi_bresp);
        end
    end
end
endtask
task axr(input [3:0] ad, output [31:0] dt, output [1:0] rs);
    integer t;
    reg dn;
begin
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    dn = 0;
    t = 0;
    while (!dn && t < 50)
    begin
        @(posedge clk);
        t++;
        if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
            s_axi_rready <= 1'b0;
            dt = s_axi_rdata;
            rs = s_axi_rresp;
            dn = 1;
        end
    end
end
endtask
task wait_a(input v);
    integer t;
begin
    t = 0;
    do
    begin
        @(posedge clk);
        t++;
    end
    while (drive_out_a !== v && t < 400);
end
endtask
// Cycles that one high phase of leg a lasts
task hi_len(output integer c);
begin
    wait_a(1'b0);
    wait_a(1'b1);
    c = 0;
    while (drive_out_a === 1'b1 && c < 400)
    begin
        @(posedge clk);
        c++;
    end
end
endtask
task chk_off(input integer c);
begin
    repeat (c)
    begin
        @(posedge clk);
        chk_w("legs", 0, {drive_out_a, drive_out_b});
    end
end
endtask
task stop_test;
begin
    if (err_total == 0 && n_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
end
endtask
initial
begin
    #160000;
    err_total++;
    stop_test;
end
// ----------
// Sequence
// ----------
initial
begin
    {rst, mode_pin, uvlo_pin, overtemp_pin, run} = 5'h10;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    n_checks = 0;
    rows[0] = {4'h0, 32'h1, 2'h0};
    rows[1] = {4'hc, 32'h0, 2'h0};
    rows[2] = {4'h2, 32'h0, 2'h2};
    rows[3] = {4'h4, 32'h00100001, 2'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
        axr(rows[i][37:34], d, r);
        chk_w("rdata", rows[i][33:2], d);
        chk_w("rresp", rows[i][1:0], r);
    end
    run <= 1'b1;
    hi_len(n);
    chk_w("ext_high", 21, n);
    // Stop with the pin low so the restart is a rising edge
    @(negedge clock_or_rate_pin);
    @(posedge clk);
    run <= 1'b0;
    repeat (WD + 20) @(posedge clk);
    chk_off(10);
    chk_w("irq_masked", 0, irq);
    axw(4'hc, 32'hf);
    repeat (3) @(posedge clk);
    chk_w("irq", 1, irq);
    axr(4'h8, d, r);
    chk_w("irq_stat", 32'h9, d);
    axw(4'h8, 32'hf);
    repeat (3) @(posedge clk);
    chk_w("irq_clr", 0, irq);
    run <= 1'b1;
    hi_len(n);
    chk_w("resume_high", 21, n);
    mode_pin <= 1'b1;
    run <= 1'b0;
    hi_len(n);
    hi_len(n);
    chk_w("osc_high", 13, n);
    axw(4'h4, 32'h8);
    hi_len(n);
    hi_len(n);
    chk_w("osc_div", 5, n);
    axw(4'h4, 32'h10);
    axw(4'h0, 32'h0);
    repeat (4) @(posedge clk);
    chk_off(10);
    axw(4'h0, 32'h1);
    for (k = 0; k < 2; k++)
    begin
        {overtemp_pin, uvlo_pin} <= k ? 2'h2 : 2'h1;
        repeat (8) @(posedge clk);
        chk_off(40);
        {overtemp_pin, uvlo_pin} <= 2'h0;
        hi_len(n);
        hi_len(n);
        chk_w("fault_resume", 13, n);
    end
    mode_pin <= 1'b0;
    repeat (WD + 20) @(posedge clk);
    chk_off(10);
    mode_pin <= 1'b1;
    hi_len(n);
    hi_len(n);
    chk_w("mode_resume", 13, n);
    stop_test;
end
endmodule // hbds_top_tb
